//--- core/msp_pkg.sv
package msp_pkg;

`include "msp_regs.svh"

typedef enum logic {
    MSP_WRITE = 1'b0,
    MSP_READ  = 1'b1
} msp_access_e;

typedef logic [`MSP_DATA_W-1:0] msp_word_t;
typedef logic [`MSP_ADDR_W-1:0] msp_addr_t;
typedef logic [`MSP_CNT_W-1:0]  msp_cnt_t;

// Link side state, clocked by the serial clock
typedef struct packed {
    msp_cnt_t                   cnt;
    msp_access_e                access;
    msp_addr_t                  addr;
    logic [`MSP_FRAME_BITS-1:0] rx;
    msp_word_t                  txData;
    logic                       fetchTgl;
} msp_lnk_s;

// Core side state, clocked by clk
typedef struct packed {
    logic [1:0]                        csSync;
    logic                              csPrev;
    logic [1:0]                        fetchSync;
    logic                              fetchPrev;
    logic                              pendClr;
    msp_addr_t                         clrAddr;
    msp_word_t                         lastData;
    logic                              writeDone;
    logic                              readDone;
    msp_word_t [`MSP_REG_DEPTH-1:0]    regs;
} msp_clk_s;

endpackage

//--- core/msp_regs.svh
`ifndef MSP_REGS_SVH
`define MSP_REGS_SVH

// ==========================================================================
// Register offsets (10-bit decoded address)
`define MSP_OFS_METERING_ENABLE             10'h000
`define MSP_OFS_CURRENT_CHANNEL_MAPPING     10'h001
`define MSP_OFS_VOLTAGE_CHANNEL_MAPPING     10'h002
`define MSP_OFS_SAG_PEAK_PERIOD_CONFIG      10'h005
`define MSP_OFS_OVER_VOLTAGE_THRESHOLD      10'h006
`define MSP_OFS_ZERO_CROSSING_CONFIG        10'h007
`define MSP_OFS_VOLTAGE_SAG_THRESHOLD       10'h008
`define MSP_OFS_PHASE_LOSS_THRESHOLD        10'h009
`define MSP_OFS_NEUTRAL_CURRENT_WARN_THRESH 10'h00A
`define MSP_OFS_OVER_CURRENT_THRESHOLD      10'h00B
`define MSP_OFS_FREQUENCY_LOW_THRESHOLD     10'h00C
`define MSP_OFS_FREQUENCY_HIGH_THRESHOLD    10'h00D
`define MSP_OFS_PARTIAL_MEASURE_POWER_CTRL  10'h00E
`define MSP_OFS_INTERRUPT0_MERGE_CONFIG     10'h00F
`define MSP_OFS_CURRENT_DETECTOR_CONTROL    10'h010
`define MSP_OFS_DETECT_THRESHOLD_CH1        10'h011
`define MSP_OFS_DETECT_THRESHOLD_CH2        10'h012
`define MSP_OFS_DETECT_THRESHOLD_CH3        10'h013
`define MSP_OFS_CURRENT_DC_OFFSET_A         10'h014
`define MSP_OFS_CURRENT_DC_OFFSET_B         10'h015
`define MSP_OFS_CURRENT_DC_OFFSET_C         10'h016
`define MSP_OFS_VOLTAGE_DC_OFFSET_A         10'h017
`define MSP_OFS_VOLTAGE_DC_OFFSET_B         10'h018
`define MSP_OFS_VOLTAGE_DC_OFFSET_C         10'h019
`define MSP_OFS_VOLTAGE_TEMP_COMP_AB        10'h01A
`define MSP_OFS_VOLTAGE_TEMP_COMP_C         10'h01B
`define MSP_OFS_PHASE_FREQUENCY_COMP        10'h01C
`define MSP_OFS_LOG_CURRENT_SEGMENT0        10'h020
`define MSP_OFS_LOG_CURRENT_SEGMENT1        10'h021
`define MSP_OFS_NOMINAL_FREQUENCY           10'h022
`define MSP_OFS_NOMINAL_TEMPERATURE         10'h023
`define MSP_OFS_PHASE_A_PHASE_COMP_SEG01    10'h024
`define MSP_OFS_PHASE_A_PHASE_COMP_SEG2     10'h025

// ==========================================================================
// Frame layout and storage
`define MSP_DATA_W      16
`define MSP_ADDR_W      10
`define MSP_CNT_W       6
`define MSP_FRAME_BITS  32
`define MSP_FETCH_BITS  6'h10
`define MSP_WRITE_BITS  6'h20
`define MSP_LAST_BIT    6'h1F
`define MSP_CNT_SAT     6'h21
`define MSP_REG_DEPTH   38
`define MSP_REG_RST     16'h0000

`endif

//--- core/msp_spi_port.sv
`timescale 1ns/10ps

`include "msp_regs.svh"

module msp_spi_port
    import msp_pkg::*;
#(
    parameter logic [`MSP_REG_DEPTH-1:0] CLR_ON_READ = {`MSP_REG_DEPTH{1'b0}}
) (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire logic                           sclk,
    input  wire logic                           csN,
    input  wire logic                           sdi,
    output logic                                sdo,
    output msp_word_t                           lastTransferData,
    output msp_word_t [`MSP_REG_DEPTH-1:0]      regFile,
    output logic                                writeDone,
    output logic                                readDone
);

    // ======================================================================
    // Address decode
    function automatic logic isMapped(input msp_addr_t a);
        case (a)
            `MSP_OFS_METERING_ENABLE,
            `MSP_OFS_CURRENT_CHANNEL_MAPPING,
            `MSP_OFS_VOLTAGE_CHANNEL_MAPPING,
            `MSP_OFS_SAG_PEAK_PERIOD_CONFIG,
            `MSP_OFS_OVER_VOLTAGE_THRESHOLD,
            `MSP_OFS_ZERO_CROSSING_CONFIG,
            `MSP_OFS_VOLTAGE_SAG_THRESHOLD,
            `MSP_OFS_PHASE_LOSS_THRESHOLD,
            `MSP_OFS_NEUTRAL_CURRENT_WARN_THRESH,
            `MSP_OFS_OVER_CURRENT_THRESHOLD,
            `MSP_OFS_FREQUENCY_LOW_THRESHOLD,
            `MSP_OFS_FREQUENCY_HIGH_THRESHOLD,
            `MSP_OFS_PARTIAL_MEASURE_POWER_CTRL,
            `MSP_OFS_INTERRUPT0_MERGE_CONFIG,
            `MSP_OFS_CURRENT_DETECTOR_CONTROL,
            `MSP_OFS_DETECT_THRESHOLD_CH1,
            `MSP_OFS_DETECT_THRESHOLD_CH2,
            `MSP_OFS_DETECT_THRESHOLD_CH3,
            `MSP_OFS_CURRENT_DC_OFFSET_A,
            `MSP_OFS_CURRENT_DC_OFFSET_B,
            `MSP_OFS_CURRENT_DC_OFFSET_C,
            `MSP_OFS_VOLTAGE_DC_OFFSET_A,
            `MSP_OFS_VOLTAGE_DC_OFFSET_B,
            `MSP_OFS_VOLTAGE_DC_OFFSET_C,
            `MSP_OFS_VOLTAGE_TEMP_COMP_AB,
            `MSP_OFS_VOLTAGE_TEMP_COMP_C,
            `MSP_OFS_PHASE_FREQUENCY_COMP,
            `MSP_OFS_LOG_CURRENT_SEGMENT0,
            `MSP_OFS_LOG_CURRENT_SEGMENT1,
            `MSP_OFS_NOMINAL_FREQUENCY,
            `MSP_OFS_NOMINAL_TEMPERATURE,
            `MSP_OFS_PHASE_A_PHASE_COMP_SEG01,
            `MSP_OFS_PHASE_A_PHASE_COMP_SEG2: isMapped = 1'b1;
            default:                          isMapped = 1'b0;
        endcase
    endfunction

    // Mapped offsets all fit the low six bits
    function automatic logic [5:0] regIdx(input msp_addr_t a);
        regIdx = a[5:0];
    endfunction

    // ======================================================================
    // State
    msp_clk_s  clkSt_ff;
    msp_clk_s  nxt_clkSt;
    msp_lnk_s  lnkSt_ff;
    msp_lnk_s  nxt_lnkSt;
    logic      frameOpen_ff;
    logic      sdo_ff;
    logic      nxt_sdo;
    logic      frameRst;
    logic      csRise;
    logic      fetchEdge;
    logic      lnkInData;
    msp_word_t readMux;

    // Select high ends the frame for the link side without any clock edge
    assign frameRst = rst | csN;

    // ======================================================================
    // Link side, serial clock domain
    // Writes only change registers after select release and clears come after
    // the fetch, so the read mux is quasi-static up to the fetch of a frame.
    always_comb begin
        if (isMapped(nxt_lnkSt.rx[`MSP_ADDR_W-1:0])) begin
            readMux = clkSt_ff.regs[regIdx(nxt_lnkSt.rx[`MSP_ADDR_W-1:0])];
        end else begin
            readMux = `MSP_REG_RST;
        end
    end

    always_comb begin
        nxt_lnkSt = lnkSt_ff;
        nxt_lnkSt.rx = {lnkSt_ff.rx[`MSP_FRAME_BITS-2:0], sdi};
        if (!frameOpen_ff) begin
            nxt_lnkSt.cnt = 6'h01;
            nxt_lnkSt.access = msp_access_e'(sdi);
        end else if (lnkSt_ff.cnt != `MSP_CNT_SAT) begin
            nxt_lnkSt.cnt = 6'(lnkSt_ff.cnt + 6'h01);
        end
        if (frameOpen_ff && nxt_lnkSt.cnt == `MSP_FETCH_BITS) begin
            // Upper five address bits are dropped here
            nxt_lnkSt.addr = nxt_lnkSt.rx[`MSP_ADDR_W-1:0];
            if (lnkSt_ff.access == MSP_READ) begin
                nxt_lnkSt.txData = readMux;
                nxt_lnkSt.fetchTgl = ~lnkSt_ff.fetchTgl;
            end
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            lnkSt_ff <= '0;
        end else begin
            lnkSt_ff <= nxt_lnkSt;
        end
    end

    // Cleared asynchronously by select so a new frame restarts the count
    always_ff @(posedge sclk or posedge frameRst) begin
        if (frameRst) begin
            frameOpen_ff <= 1'b0;
        end else begin
            frameOpen_ff <= 1'b1;
        end
    end

    // Data phase spans counts 16 to 31, one bit per falling edge
    assign lnkInData = (lnkSt_ff.access == MSP_READ) &&
                       (lnkSt_ff.cnt >= `MSP_FETCH_BITS) &&
                       (lnkSt_ff.cnt <= `MSP_LAST_BIT);

    always_comb begin
        nxt_sdo = 1'b0;
        if (lnkInData) begin
            nxt_sdo = lnkSt_ff.txData[4'(`MSP_LAST_BIT - lnkSt_ff.cnt)];
        end
    end

    // Output is low whenever select is released
    always_ff @(negedge sclk or posedge frameRst) begin
        if (frameRst) begin
            sdo_ff <= 1'b0;
        end else begin
            sdo_ff <= nxt_sdo;
        end
    end

    // ======================================================================
    // Core side, clk domain
    // Link words are read only when quiet: after select release for a write,
    // after the fetch toggle for a read. Needs select high for four clk cycles.
    assign csRise    = clkSt_ff.csSync[1] & ~clkSt_ff.csPrev;
    assign fetchEdge = clkSt_ff.fetchSync[1] ^ clkSt_ff.fetchPrev;

    always_comb begin
        nxt_clkSt = clkSt_ff;
        nxt_clkSt.csSync = {clkSt_ff.csSync[0], csN};
        nxt_clkSt.csPrev = clkSt_ff.csSync[1];
        nxt_clkSt.fetchSync = {clkSt_ff.fetchSync[0], lnkSt_ff.fetchTgl};
        nxt_clkSt.fetchPrev = clkSt_ff.fetchSync[1];
        nxt_clkSt.writeDone = 1'b0;
        nxt_clkSt.readDone = 1'b0;
        nxt_clkSt.pendClr = 1'b0;
        // Clear one cycle after the holding register took the value
        if (clkSt_ff.pendClr && isMapped(clkSt_ff.clrAddr)) begin
            if (CLR_ON_READ[regIdx(clkSt_ff.clrAddr)]) begin
                nxt_clkSt.regs[regIdx(clkSt_ff.clrAddr)] = `MSP_REG_RST;
            end
        end
        if (fetchEdge) begin
            nxt_clkSt.lastData = lnkSt_ff.txData;
            nxt_clkSt.readDone = 1'b1;
            nxt_clkSt.pendClr = 1'b1;
            nxt_clkSt.clrAddr = lnkSt_ff.addr;
        end
        // Short, long or read frames commit no write data to the registers
        if (csRise && lnkSt_ff.cnt == `MSP_WRITE_BITS && lnkSt_ff.access == MSP_WRITE
            && isMapped(lnkSt_ff.addr)) begin
            nxt_clkSt.regs[regIdx(lnkSt_ff.addr)] = lnkSt_ff.rx[`MSP_DATA_W-1:0];
            nxt_clkSt.writeDone = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clkSt_ff <= '0;
            clkSt_ff.csSync <= 2'h3;
            clkSt_ff.csPrev <= 1'b1;
        end else begin
            clkSt_ff <= nxt_clkSt;
        end
    end

    // ======================================================================
    // Outputs
    assign sdo              = sdo_ff;
    assign lastTransferData = clkSt_ff.lastData;
    assign regFile          = clkSt_ff.regs;
    assign writeDone        = clkSt_ff.writeDone;
    assign readDone         = clkSt_ff.readDone;

    // ======================================================================
    // Checks
    write_commit_a: assert property (
        @(posedge clk) disable iff (rst)
        (csRise && lnkSt_ff.cnt == `MSP_WRITE_BITS && lnkSt_ff.access == MSP_WRITE
         && isMapped(lnkSt_ff.addr))
        |=> writeDone && regFile[regIdx($past(lnkSt_ff.addr))] == $past(lnkSt_ff.rx[15:0]))
        else $error("Well formed write did not commit");

    write_reject_a: assert property (
        @(posedge clk) disable iff (rst)
        writeDone |-> $past(csRise) && $past(lnkSt_ff.cnt) == `MSP_WRITE_BITS)
        else $error("Write committed without exactly 32 clocks");

    write_stable_a: assert property (
        @(posedge clk) disable iff (rst)
        (!csRise && !clkSt_ff.pendClr) |=> $stable(regFile))
        else $error("Register changed outside select release");

    hold_update_a: assert property (
        @(posedge clk) disable iff (rst)
        fetchEdge |=> readDone && lastTransferData == $past(lnkSt_ff.txData))
        else $error("Holding register not updated by read");

    clear_order_a: assert property (
        @(posedge clk) disable iff (rst)
        clkSt_ff.pendClr |-> readDone && $past(fetchEdge)
        ##1 lastTransferData == $past(lastTransferData))
        else $error("Clear came before holding update");

    fetch_point_a: assert property (
        @(posedge sclk) disable iff (rst || csN)
        (lnkSt_ff.fetchTgl != $past(lnkSt_ff.fetchTgl))
        |-> lnkSt_ff.cnt == `MSP_FETCH_BITS && lnkSt_ff.access == MSP_READ)
        else $error("Fetch outside the sixteenth clock of a read");

    flag_capture_a: assert property (
        @(posedge sclk) disable iff (rst || csN)
        (lnkSt_ff.cnt == 6'h01) |=> lnkSt_ff.access == $past(lnkSt_ff.access, 1))
        else $error("Access flag changed inside a frame");

    sdo_order_a: assert property (
        @(posedge sclk) disable iff (rst || csN)
        (lnkInData && lnkSt_ff.cnt == `MSP_FETCH_BITS)
        |-> sdo_ff == lnkSt_ff.txData[15] ##1 sdo_ff == lnkSt_ff.txData[14])
        else $error("Read data not msb first after address");

    sdo_quiet_a: assert property (
        @(posedge sclk) disable iff (rst || csN)
        (lnkSt_ff.access == MSP_WRITE) |-> !sdo_ff)
        else $error("Output driven during a write frame");

endmodule

//--- dv/msp_spi_master.sv
`timescale 1ns/10ps

// ==========================================================================
// Serial master model; clock idles low and stands still between frames
module msp_spi_master (
    output logic      sclk,
    output logic      csN,
    output logic      sdi,
    input  wire logic sdo
);
    initial begin
        sclk = 1'b0;
        csN  = 1'b1;
        sdi  = 1'b0;
    end

    // Short or long counts only when a test asks for a refusal
    task automatic xfer(input logic [31:0] frame, input int nClk, input int halfNs,
                        output logic [15:0] rdData);
        logic [32:0] bits;
        bits = {frame, 1'b0};
        rdData = 16'h0000;
        #1 csN = 1'b0;
        for (int i = 0; i < nClk; i++) begin
            sdi = bits[32];
            bits = bits << 1;
            #(halfNs) sclk = 1'b1;
            if (i >= 16) rdData = {rdData[14:0], sdo};
            #(halfNs) sclk = 1'b0;
        end
        #(halfNs) csN = 1'b1;
        // Released line must not keep the last bit
        sdi = ~sdi;
    endtask
endmodule

//--- dv/msp_spi_port_tb_top.sv
`timescale 1ns/10ps

`include "msp_regs.svh"

// ==========================================================================
// Self-checking bench for the serial register port
module msp_spi_port_tb_top
    import msp_pkg::*;
;
    typedef struct packed {
        logic [9:0] ofs;
        logic [4:0] hi;
        msp_word_t  data;
        logic       mapped;
    } msp_row_s;

    // Only offset 0x0E clears on read, to reach the clear path
    localparam logic [`MSP_REG_DEPTH-1:0] CLR_MASK = 38'h4000;

    logic                           clk;
    logic                           rst;
    logic                           sclk;
    logic                           csN;
    logic                           sdi;
    logic                           sdo;
    logic                           writeDone;
    logic                           readDone;
    msp_word_t                      lastTransferData;
    msp_word_t [`MSP_REG_DEPTH-1:0] regFile;
    msp_word_t                      rd;
    msp_word_t                      expW;
    int                             failCount = 0;
    int                             nTests = 0;
    int                             wrCnt = 0;
    int                             rdCnt = 0;
    msp_row_s                       rows [5] = '{
        '{10'h000, 5'h1F, 16'hA5C3, 1'b1},
        '{10'h025, 5'h00, 16'hFFFF, 1'b1},
        '{10'h00A, 5'h15, 16'h8001, 1'b1},
        '{10'h003, 5'h0A, 16'h1234, 1'b0},
        '{10'h01C, 5'h07, 16'h0001, 1'b1}
    };

    msp_spi_port #(.CLR_ON_READ(CLR_MASK)) dut (
        .clk              (clk),
        .rst              (rst),
        .sclk             (sclk),
        .csN              (csN),
        .sdi              (sdi),
        .sdo              (sdo),
        .lastTransferData (lastTransferData),
        .regFile          (regFile),
        .writeDone        (writeDone),
        .readDone         (readDone)
    );

    msp_spi_master master (
        .sclk (sclk),
        .csN  (csN),
        .sdi  (sdi),
        .sdo  (sdo)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Pulses are counted here so frames may overlap them
    always @(posedge clk) begin
        if (writeDone === 1'b1) wrCnt++;
        if (readDone === 1'b1) rdCnt++;
    end

    task automatic chkW(input msp_word_t got, input msp_word_t exp, input string what);
        nTests++;
        if (got !== exp) begin
            failCount++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chkN(input int got, input int exp, input string what);
        nTests++;
        if (got != exp) begin
            failCount++;
            $display("Error at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask

    task automatic endOfTest;
        if (failCount == 0 && nTests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // One frame, then a bounded wait for the expected pulses
    task automatic frame(input logic acc, input logic [4:0] hi, input logic [9:0] ofs,
                         input msp_word_t data, input int nClk, input int halfNs,
                         input int dWr, input int dRd);
        int w0;
        int r0;
        w0 = wrCnt;
        r0 = rdCnt;
        master.xfer({acc, hi, ofs, data}, nClk, halfNs, rd);
        for (int i = 0; i < 10 && (wrCnt != w0 + dWr || rdCnt != r0 + dRd); i++)
            @(posedge clk);
        repeat (5) @(posedge clk);
        chkN(wrCnt - w0, dWr, "writes");
        chkN(rdCnt - r0, dRd, "reads");
    endtask

    initial begin
        #900000;
        failCount++;
        $display("Error at %0t: run hung", $time);
        endOfTest();
    end

    initial begin
        rst = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        // Ordinary cases: write, then read back with other upper address bits
        foreach (rows[i]) begin
            expW = rows[i].mapped ? rows[i].data : 16'h0000;
            frame(1'b0, rows[i].hi, rows[i].ofs, rows[i].data, 32, 3, int'(rows[i].mapped), 0);
            chkW(regFile[rows[i].ofs], expW, "stored");
            frame(1'b1, ~rows[i].hi, rows[i].ofs, 16'h0000, 32, 3, 0, 1);
            chkW(rd, expW, "serial read");
            chkW(lastTransferData, expW, "holding");
        end
        // Wrong clock counts never commit
        for (int n = 31; n <= 33; n += 2) begin
            frame(1'b0, 5'h00, 10'h000, 16'h1111, n, 3, 0, 0);
            chkW(regFile[0], 16'hA5C3, "refused write");
        end
        // Too short a read fetches nothing
        frame(1'b1, 5'h00, 10'h025, 16'h0000, 15, 3, 0, 0);
        chkW(lastTransferData, 16'h0001, "short read");
        // Slow clock, back to back, clear on read
        frame(1'b0, 5'h03, 10'h00E, 16'h5AA5, 32, 40, 1, 0);
        frame(1'b1, 5'h00, 10'h00E, 16'h0000, 32, 40, 0, 1);
        chkW(rd, 16'h5AA5, "slow read");
        chkW(lastTransferData, 16'h5AA5, "holding before clear");
        chkW(regFile[14], 16'h0000, "cleared");
        chkW({15'h0000, sdo}, 16'h0000, "sdo idle");
        // Mid-run reset returns the registers and the holding register to zero
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chkW(regFile[37], 16'h0000, "reset reg");
        chkW(lastTransferData, 16'h0000, "reset holding");
        frame(1'b0, 5'h00, 10'h001, 16'h00C3, 32, 3, 1, 0);
        chkW(regFile[1], 16'h00C3, "after reset");
        endOfTest();
    end
endmodule
